// ### src/auto_reload_timer_split.sv
// Sixteen-bit auto-reload timer that can split into two 8-bit timers.
//
// How it works
// [RQ1] Count held as low and high bytes.
// [RQ2] Split bit clear gives 16-bit auto-reload.
// [RQ3] Tick: clock, clock/12, or synced external/8.
// [RQ4] 16-bit wrap reloads and sets high flag.
// [RQ5] 16-bit overflow interrupts while timer enabled.
// [RQ6] Low byte wrap interrupts when also enabled.
// [RQ7] Split set, capture clear: two 8-bit timers.
// [RQ8] Each byte reloads from own reload register.
// [RQ9] Split: run bit gates high byte only.
// [RQ10] Per-byte select picks clock or shared slow tick.
// [RQ11] Split: each byte wrap sets its flag.
// [RQ12] Split: interrupt on high, or either if enabled.
// [RQ13] Flags cleared only by software writes.
// [RQ14] Handler reads both flags to find source.
// [RQ15] Low wrap sets low flag in any mode.
// [RQ16] Counting needs run bit; split gates high.
// [RQ17] One level interrupt request to the core.
// [RQ18] Reload on wrap tick; stopped counter holds.
//
// The register offsets and the plain strobed port were decided locally.
module auto_reload_timer_split
  import timer_pkg::*;
#(
  parameter int SYS_DIV = SYS_DIVIDE,
  parameter int EXT_DIV = EXT_DIVIDE
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  input  wire logic              ext_clk,
  output logic      [DATA_W-1:0] rdata,
  output logic                   irq
);

  bus_req_type    req;
  control_type    control_reg;
  control_type    control_next;
  clock_ctrl_type clock_ctrl_reg;
  logic [7:0]     irq_enable_reg;
  logic [7:0]     reload_low_reg;
  logic [7:0]     reload_high_reg;
  logic [7:0]     count_low_reg;
  logic [7:0]     count_low_next;
  logic [7:0]     count_high_reg;
  logic [7:0]     count_high_next;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  logic           irq_reg;
  logic           irq_next;

  logic           tick_sys_div;
  logic           tick_ext_div;
  logic           slow_tick;
  logic [1:0]     byte_select;
  logic [1:0]     byte_tick;

  logic           wr_control;
  logic           wr_reload_low;
  logic           wr_reload_high;
  logic           wr_count_low;
  logic           wr_count_high;
  logic           wr_clock_ctrl;
  logic           wr_irq_enable;

  logic           split;
  logic           timer_irq_enable;
  logic           tick16;
  logic           low_step;
  logic           high_step;
  logic           low_wrap;
  logic           high_wrap;
  logic           low_reload;
  logic           set_high_flag;
  logic           set_low_flag;
  logic [7:0]     wdata_control;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  tick_source #(
    .SYS_DIV (SYS_DIV),
    .EXT_DIV (EXT_DIV)
  ) u_tick_source (
    .clk          (clk),
    .nrst         (nrst),
    .ext_clk      (ext_clk),
    .tick_sys_div (tick_sys_div),
    .tick_ext_div (tick_ext_div)
  );

  // Address decode.
  assign wr_control     = req.wr & (req.addr == CONTROL_OFFSET);
  assign wr_reload_low  = req.wr & (req.addr == RELOAD_LOW_OFFSET);
  assign wr_reload_high = req.wr & (req.addr == RELOAD_HIGH_OFFSET);
  assign wr_count_low   = req.wr & (req.addr == COUNT_LOW_OFFSET); // [RQ1]
  assign wr_count_high  = req.wr & (req.addr == COUNT_HIGH_OFFSET); // [RQ1]
  assign wr_clock_ctrl  = req.wr & (req.addr == CLOCK_CTRL_OFFSET);
  assign wr_irq_enable  = req.wr & (req.addr == IRQ_ENABLE_OFFSET);

  // The external select is shared; each byte may still bypass it with
  // its own select bit and run straight off the system clock.
  assign slow_tick = control_reg.external_source_select
                   ? tick_ext_div : tick_sys_div; // [RQ3]
  assign byte_select = {clock_ctrl_reg.high_byte_clock_select,
                        clock_ctrl_reg.low_byte_clock_select};

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_byte_tick
      assign byte_tick[i] = byte_select[i] ? 1'b1 : slow_tick; // [RQ10]
    end
  endgenerate

  assign split            = control_reg.split_mode_select;
  assign timer_irq_enable = irq_enable_reg[7];

  // In 16-bit mode the whole count follows the low byte's clock choice.
  assign tick16 = ~split & byte_tick[0] & control_reg.run_control; // [RQ2]

  // Split mode with capture enabled is not a counting mode here, so
  // both bytes hold rather than run in an undefined way.
  assign low_step  = split
                   ? (byte_tick[0] & ~clock_ctrl_reg.capture_enable) // [RQ9]
                   : tick16; // [RQ16]
  assign high_step = split
                   ? (byte_tick[1] & control_reg.run_control
                      & ~clock_ctrl_reg.capture_enable) // [RQ7]
                   : (tick16 & (count_low_reg == BYTE_ALL_ONES)); // [RQ2]

  assign low_wrap  = low_step & (count_low_reg == BYTE_ALL_ONES);
  assign high_wrap = high_step & (count_high_reg == BYTE_ALL_ONES);

  // In 16-bit mode the low byte reloads only on the full-count wrap;
  // otherwise it carries into the high byte and rolls to zero.
  assign low_reload = low_wrap & (split | high_wrap); // [RQ4] [RQ8]

  assign set_high_flag = high_wrap; // [RQ4] [RQ11]
  assign set_low_flag  = low_wrap; // [RQ11] [RQ15]

  always_comb
  begin
    count_low_next = count_low_reg;
    if (wr_count_low)
    begin
      count_low_next = req.wdata;
    end
    else if (low_step)
    begin
      count_low_next = low_reload ? reload_low_reg
                                  : count_low_reg + 8'h01; // [RQ18]
    end
  end

  always_comb
  begin
    count_high_next = count_high_reg;
    if (wr_count_high)
    begin
      count_high_next = req.wdata;
    end
    else if (high_step)
    begin
      count_high_next = high_wrap ? reload_high_reg
                                  : count_high_reg + 8'h01; // [RQ8] [RQ18]
    end
  end

  // A hardware set in the same cycle as a software clear wins, so no
  // overflow is lost; only a write may ever clear a flag.
  assign wdata_control = wr_control
                       ? ((req.wdata & CONTROL_WMASK)
                          | (control_reg & ~CONTROL_WMASK))
                       : control_reg;

  always_comb
  begin
    control_next = wdata_control;
    control_next.high_overflow_flag = wdata_control[7]
                                    | set_high_flag; // [RQ13]
    control_next.low_overflow_flag  = wdata_control[6]
                                    | set_low_flag; // [RQ13]
  end

  // Both flags stay readable so the handler can tell the source apart.
  assign irq_next = timer_irq_enable
                  & (control_reg.high_overflow_flag // [RQ5] [RQ12]
                     | (control_reg.low_overflow_flag
                        & control_reg.low_byte_irq_enable)); // [RQ6] [RQ17]

  always_comb
  begin
    rdata_next = BYTE_RESET;
    case (req.addr)
      CONTROL_OFFSET:     rdata_next = control_reg; // [RQ14]
      RELOAD_LOW_OFFSET:  rdata_next = reload_low_reg;
      RELOAD_HIGH_OFFSET: rdata_next = reload_high_reg;
      COUNT_LOW_OFFSET:   rdata_next = count_low_reg; // [RQ1]
      COUNT_HIGH_OFFSET:  rdata_next = count_high_reg; // [RQ1]
      CLOCK_CTRL_OFFSET:  rdata_next = clock_ctrl_reg;
      IRQ_ENABLE_OFFSET:  rdata_next = irq_enable_reg;
      default:            rdata_next = BYTE_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control_reg    <= control_type'(BYTE_RESET);
      count_low_reg  <= BYTE_RESET;
      count_high_reg <= BYTE_RESET;
      irq_reg        <= 1'b0;
    end
    else
    begin
      control_reg    <= control_next;
      count_low_reg  <= count_low_next;
      count_high_reg <= count_high_next;
      irq_reg        <= irq_next; // [RQ17]
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reload_low_reg  <= BYTE_RESET;
      reload_high_reg <= BYTE_RESET;
      clock_ctrl_reg  <= clock_ctrl_type'(BYTE_RESET);
      irq_enable_reg  <= BYTE_RESET;
    end
    else
    begin
      if (wr_reload_low)
      begin
        reload_low_reg <= req.wdata;
      end
      if (wr_reload_high)
      begin
        reload_high_reg <= req.wdata;
      end
      if (wr_clock_ctrl)
      begin
        clock_ctrl_reg <= clock_ctrl_type'(req.wdata & CLOCK_CTRL_WMASK);
      end
      if (wr_irq_enable)
      begin
        irq_enable_reg <= req.wdata & IRQ_ENABLE_WMASK;
      end
    end
  end

  // Read data is valid only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= BYTE_RESET;
    end
    else
    begin
      rdata_reg <= req.rd ? rdata_next : BYTE_RESET;
    end
  end

  assign rdata = rdata_reg;
  assign irq   = irq_reg;

endmodule // auto_reload_timer_split

// ### shared/timer_pkg.sv
// Register map, field layouts, reset values and divider counts of the timer.
package timer_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;

  localparam logic [7:0]  CONTROL_OFFSET    = 8'h91;
  localparam logic [7:0]  RELOAD_LOW_OFFSET = 8'h92;
  localparam logic [7:0]  RELOAD_HIGH_OFFSET = 8'h93;
  localparam logic [7:0]  COUNT_LOW_OFFSET  = 8'h94;
  localparam logic [7:0]  COUNT_HIGH_OFFSET = 8'h95;
  localparam logic [7:0]  CLOCK_CTRL_OFFSET = 8'h96;
  localparam logic [7:0]  IRQ_ENABLE_OFFSET = 8'h97;

  localparam logic [7:0]  BYTE_RESET        = 8'h00;
  localparam logic [7:0]  BYTE_ALL_ONES     = 8'hff;
  localparam logic [7:0]  CONTROL_WMASK     = 8'hed;
  localparam logic [7:0]  CLOCK_CTRL_WMASK  = 8'h07;
  localparam logic [7:0]  IRQ_ENABLE_WMASK  = 8'h80;

  localparam int          SYS_DIVIDE        = 12;
  localparam int          EXT_DIVIDE        = 8;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic unused4;
    logic split_mode_select;
    logic run_control;
    logic unused1;
    logic external_source_select;
  } control_type;

  // Clock control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [4:0] unused;
    logic       capture_enable;
    logic       high_byte_clock_select;
    logic       low_byte_clock_select;
  } clock_ctrl_type;

  // Register port request bundle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

endpackage

// ### src/tick_source.sv
// Slow tick generation: system clock divided down and external source
// synchronised and divided down.
module tick_source
  import timer_pkg::*;
#(
  parameter int SYS_DIV = SYS_DIVIDE,
  parameter int EXT_DIV = EXT_DIVIDE
)
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ext_clk,
  output logic      tick_sys_div,
  output logic      tick_ext_div
);

  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic [SW-1:0] sys_cnt_reg;
  logic [EW-1:0] ext_cnt_reg;
  logic          ext_meta_reg;
  logic          ext_sync_reg;
  logic          ext_prev_reg;
  logic          sys_wrap;
  logic          ext_rise;
  logic          ext_wrap;

  assign sys_wrap = (sys_cnt_reg == SYS_LAST);
  // Only the second and third stages are looked at; the first may be
  // metastable.
  assign ext_rise = ext_sync_reg & ~ext_prev_reg;
  assign ext_wrap = ext_rise & (ext_cnt_reg == EXT_LAST);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sys_cnt_reg  <= '0;
      ext_cnt_reg  <= '0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      tick_sys_div <= 1'b0;
      tick_ext_div <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ext_clk; // [RQ3]
      ext_sync_reg <= ext_meta_reg; // [RQ3]
      ext_prev_reg <= ext_sync_reg;
      sys_cnt_reg  <= sys_wrap ? '0 : sys_cnt_reg + 1'b1;
      if (ext_rise)
      begin
        ext_cnt_reg <= ext_wrap ? '0 : ext_cnt_reg + 1'b1;
      end
      tick_sys_div <= sys_wrap; // [RQ3]
      tick_ext_div <= ext_wrap; // [RQ3]
    end
  end

endmodule // tick_source

// ### dv/timer_chk.sv
// Port-level assertion checker for the split auto-reload timer.
module timer_chk
  import timer_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic              ext_clk,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_reg;
  logic run_reg;
  wire  ctrl_wr = wr && addr == CONTROL_OFFSET;

  // Shadows of software-written bits; hardware never alters either.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      en_reg <= 1'b0;
    else if (wr && addr == IRQ_ENABLE_OFFSET)
      en_reg <= wdata[7];

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      run_reg <= 1'b0;
    else if (ctrl_wr)
      run_reg <= wdata[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (rd && (addr < CONTROL_OFFSET
    || addr > IRQ_ENABLE_OFFSET) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL_RSV: assert property (rd && addr == CONTROL_OFFSET
    |=> rdata[4] == 1'b0 && rdata[1] == 1'b0)
    else $error("control reserved bits set");
  AST_IRQEN_RSV: assert property (rd && addr == IRQ_ENABLE_OFFSET
    |=> rdata[6:0] == 7'h00)
    else $error("enable reserved bits set");
  AST_RELOAD_RB: assert property (wr && (addr == RELOAD_LOW_OFFSET
    || addr == RELOAD_HIGH_OFFSET) ##2 (rd && addr == $past(addr, 2))
    |=> rdata == $past(wdata, 3))
    else $error("reload readback wrong");
  AST_STICKY: assert property (rd && addr == CONTROL_OFFSET
    ##1 !wr ##1 rd && addr == CONTROL_OFFSET
    |=> (rdata[7:6] & $past(rdata[7:6], 2)) == $past(rdata[7:6], 2))
    else $error("flag cleared by hardware");
  AST_IRQ_OFF: assert property (!$past(en_reg) |-> !irq)
    else $error("irq while disabled");
  AST_HOLD_HIGH: assert property (wr && addr == COUNT_HIGH_OFFSET
    && !run_reg ##2 (rd && addr == COUNT_HIGH_OFFSET && !run_reg)
    |=> rdata == $past(wdata, 3))
    else $error("stopped high byte moved");
endmodule // timer_chk

bind auto_reload_timer_split timer_chk timer_chk_inst (.clk(clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .ext_clk(ext_clk), .rdata(rdata), .irq(irq));

// ### dv/test_auto_reload_timer_split.sv
// Self-checking bench for the split auto-reload timer.
module test_auto_reload_timer_split
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ext_clk = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic [7:0]  d;
  int          mismatches = 0;
  int          samples_checked = 0;
  // Address, write value, expected readback; counts go first while stopped.
  logic [23:0] rows [10] = '{24'h941212, 24'h953434, 24'h92a5a5,
    24'h935a5a, 24'h97ff80, 24'h90ff00, 24'h96ff07, 24'h960000,
    24'h912929, 24'h910000};

  always #20 clk = ~clk;

  auto_reload_timer_split auto_reload_timer_split_inst (.clk(clk),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .ext_clk(ext_clk), .rdata(rdata), .irq(irq));

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check1(input logic g, input logic e);
    check8({7'h00, g}, {7'h00, e});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe is taken.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 40 && irq !== 1'b1; i++)
      @(posedge clk) #1;
    if (irq !== 1'b1)
    begin
      mismatches++;
      $display("ERROR %0t: irq timeout", $time);
      wrap_up();
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(8'(8'h90 + i));
      check8(d, 8'h00);
    end
    check1(irq, 1'b0);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr_reg(rows[i][23:16], rows[i][15:8]);
      rd_reg(rows[i][23:16]);
      check8(d, rows[i][7:0]);
    end
    $display("register test done");
    // Full 16-bit wrap from 0xfffd with reload 0x1234 at full rate.
    wr_reg(8'h93, 8'h12);
    wr_reg(8'h92, 8'h34);
    wr_reg(8'h95, 8'hff);
    wr_reg(8'h94, 8'hfd);
    wr_reg(8'h96, 8'h01);
    wr_reg(8'h97, 8'h80);
    wr_reg(8'h91, 8'h04);
    wait_irq();
    wr_reg(8'h91, 8'hc0);
    rd_reg(8'h91);
    check8(d, 8'hc0);
    rd_reg(8'h91);
    check8(d, 8'hc0);
    rd_reg(8'h95);
    check8(d, 8'h12);
    rd_reg(8'h94);
    check1(d >= 8'h34 && d < 8'h40, 1'b1);
    check1(irq, 1'b1);
    wr_reg(8'h91, 8'h00);
    rd_reg(8'h91);
    check8(d, 8'h00);
    check1(irq, 1'b0);
    $display("wide wrap test done");
    // Low byte carry only, with and without the low interrupt enable.
    for (int len = 0; len < 2; len++)
    begin
      wr_reg(8'h95, 8'h00);
      wr_reg(8'h94, 8'hfe);
      wr_reg(8'h91, {2'b00, len[0], 5'b00100});
      if (len == 1)
        wait_irq();
      else
        repeat (12) @(posedge clk);
      rd_reg(8'h91);
      check8(d, {2'b01, len[0], 5'b00100});
      check1(irq, len[0]);
      wr_reg(8'h91, 8'h00);
    end
    $display("low carry test done");
    // Split: low runs alone, then the run bit releases the high byte.
    wr_reg(8'h92, 8'h80);
    wr_reg(8'h93, 8'h40);
    wr_reg(8'h94, 8'hfd);
    wr_reg(8'h95, 8'hfd);
    wr_reg(8'h96, 8'h03);
    wr_reg(8'h91, 8'h08);
    repeat (12) @(posedge clk);
    rd_reg(8'h95);
    check8(d, 8'hfd);
    rd_reg(8'h91);
    check8(d, 8'h48);
    check1(irq, 1'b0);
    rd_reg(8'h94);
    check1(d >= 8'h80 && d < 8'ha0, 1'b1);
    wr_reg(8'h91, 8'h0c);
    wait_irq();
    rd_reg(8'h95);
    check1(d >= 8'h40 && d < 8'h50, 1'b1);
    rd_reg(8'h91);
    check8(d, 8'h8c);
    wr_reg(8'h91, 8'h00);
    $display("split test done");
    // Slow ticks: system clock over twelve, then external edges over eight.
    wr_reg(8'h96, 8'h00);
    wr_reg(8'h95, 8'h00);
    wr_reg(8'h94, 8'h00);
    wr_reg(8'h91, 8'h04);
    repeat (120) @(posedge clk);
    wr_reg(8'h91, 8'h00);
    rd_reg(8'h94);
    check1(d >= 8'h09 && d <= 8'h0b, 1'b1);
    wr_reg(8'h94, 8'h00);
    wr_reg(8'h91, 8'h05);
    repeat (32)
    begin
      repeat (3) @(posedge clk);
      ext_clk <= ~ext_clk;
    end
    repeat (8) @(posedge clk);
    wr_reg(8'h91, 8'h01);
    rd_reg(8'h94);
    check8(d, 8'h02);
    $display("tick source test done");
    wrap_up();
  end
endmodule // test_auto_reload_timer_split
